//--- hw/tcr_line_gate.sv
`default_nettype none

// Gates raw transmitter requests with the enable and backplane setting.
module tcr_line_gate
  import tcr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic transmit_enable_bit,
  input wire logic backplane,
  input wire tcr_line_t raw_req,
  output tcr_line_t line_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Registered gating; outputs are active high requests, idle low.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      line_out <= '0;
    end
    else
    begin
      line_out.line_driver_enable_out <= raw_req.line_driver_enable_out
                                         & transmit_enable_bit;
      // Pulse outputs are only gated when not in backplane mode.
      line_out.line_pulse_out_a <= raw_req.line_pulse_out_a
                                   & (transmit_enable_bit | backplane);
      line_out.line_pulse_out_b <= raw_req.line_pulse_out_b
                                   & (transmit_enable_bit | backplane);
    end
  end

endmodule : tcr_line_gate

`default_nettype wire

//--- hw/tcr_pkg.sv
// Overview of operation
// - Low pointer byte supplies RAM address bits 7-0.
// - High pointer bits 2-0 supply address bits 10-8.
// - Selector routes the indirect window register.
// - Two low selector bits shared by both registers.
// - Configuration write clears selector bit two.
// - Configuration bit 7 holds software reset.
// - Software reset keeps interface type and configuration.
// - Software reset clears status, next ID, diagnostics.
// - Configuration bit 6 enables command chaining.
// - Transmit enable low silences driver enable; pulse outputs also, unless backplane set.
// - Transmit enable clears to zero on reset.
`default_nettype none

package tcr_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [4:0] TCR_OFS_PTR_HIGH = 5'h08;
  localparam logic [4:0] TCR_OFS_PTR_LOW = 5'h0c;
  localparam logic [4:0] TCR_OFS_SELECT = 5'h10;
  localparam logic [4:0] TCR_OFS_CONFIG = 5'h14;
  localparam logic [4:0] TCR_OFS_WINDOW = 5'h1c;
  localparam logic [4:0] TCR_OFS_STATUS = 5'h00;
  // Diagnostic flags are read-only; a write here answers SLVERR.
  localparam logic [4:0] TCR_OFS_DIAG = 5'h04;

  // Field positions.
  localparam int TCR_CFG_RESET_BIT = 7;
  localparam int TCR_CFG_CHAIN_BIT = 6;
  localparam int TCR_CFG_TRANSMIT_ENABLE_BIT_BIT = 5;
  localparam int TCR_CFG_BACKPLANE_BIT = 2;
  localparam int TCR_SEL_BIT2 = 2;

  // Reset values.
  localparam logic [7:0] TCR_CONFIG_RST = 8'h00;
  localparam logic [7:0] TCR_BYTE_RST = 8'h00;
  localparam logic [2:0] TCR_SEL_RST = 3'h0;

  // AXI responses.
  localparam logic [1:0] TCR_RESP_OKAY = 2'h0;
  localparam logic [1:0] TCR_RESP_SLVERR = 2'h2;

  // Indirect window selector codes.
  typedef enum logic [2:0] {
    TCR_WIN_TENTATIVE = 3'h0,
    TCR_WIN_NODE_ID = 3'h1,
    TCR_WIN_SETUP1 = 3'h2,
    TCR_WIN_NEXT_ID = 3'h3,
    TCR_WIN_SETUP2 = 3'h4
  } tcr_win_t;

  // Line output group carried together.
  typedef struct packed {
    logic line_driver_enable_out;
    logic line_pulse_out_a;
    logic line_pulse_out_b;
  } tcr_line_t;

endpackage : tcr_pkg

`default_nettype wire

//--- hw/tcr_regs.sv
`default_nettype none

// Pointer, indirect select and configuration registers behind AXI4-Lite.
module tcr_regs
  import tcr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite slave.
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interface type latched at hard reset release.
  input wire logic host_iface_mode,
  // Status bits set by the protocol engine.
  input wire logic [7:0] status_set,
  input wire logic [7:0] diag_set,
  input wire logic [7:0] next_id_in,
  input wire logic next_id_load,
  // Raw transmitter requests.
  input wire tcr_line_t raw_req,
  // Outputs towards the rest of the controller.
  output logic [10:0] ram_addr,
  output logic chaining_enable,
  output logic soft_reset,
  output logic iface_mode,
  output logic [7:0] tentative_id,
  output logic [7:0] node_id,
  output logic [7:0] setup1,
  output logic [7:0] setup2,
  output tcr_line_t line_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Storage.
  logic [7:0] ram_pointer_low_reg; // Low address byte.
  logic [7:0] ptr_high_reg; // High pointer register.
  logic [2:0] sel_reg; // Shared selector storage.
  logic [7:0] cfg_reg; // Configuration bits 7, 6, 5, 4, 3 and 2.
  logic [7:0] status_reg; // Status flags.
  logic [7:0] diag_reg; // Diagnostic flags.
  logic [7:0] next_id_reg; // Next ID.
  logic [7:0] tent_reg; // Tentative ID.
  logic [7:0] node_reg; // Node ID.
  logic [7:0] setup1_reg; // Setup 1.
  logic [7:0] setup2_reg; // Setup 2.
  logic iface_reg; // Detected host interface type.
  logic iface_taken_reg; // Set once the type has been latched.

  // Write channel holding.
  logic aw_held_reg;
  logic w_held_reg;
  logic [4:0] waddr_reg;
  logic [7:0] wbyte_reg;
  logic wlane_reg;

  logic wr_fire; // Both halves of a write present.
  logic [7:0] wr_byte;
  logic sreset; // Software reset level.

  ////////////////////////////////////////////////////////////////////////////////
  // Returns the indirect register selected by a code, zero if reserved.
  function automatic logic [7:0] win_read(input logic [2:0] code, input logic [7:0] t,
                                          input logic [7:0] n, input logic [7:0] s1,
                                          input logic [7:0] nx, input logic [7:0] s2);
    case (code)
      TCR_WIN_TENTATIVE: win_read = t;
      TCR_WIN_NODE_ID: win_read = n;
      TCR_WIN_SETUP1: win_read = s1;
      TCR_WIN_NEXT_ID: win_read = nx;
      TCR_WIN_SETUP2: win_read = s2;
      default: win_read = 8'h00;
    endcase
  endfunction : win_read

  assign sreset = cfg_reg[TCR_CFG_RESET_BIT];
  assign wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  assign wr_byte = wbyte_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Write address and data are captured independently in either order.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      waddr_reg <= 5'h00;
      wbyte_reg <= 8'h00;
      wlane_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= TCR_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        waddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        wbyte_reg <= s_axi_wdata[7:0];
        wlane_reg <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        // Response follows both halves; unmapped offsets answer SLVERR.
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (waddr_reg)
          TCR_OFS_PTR_HIGH, TCR_OFS_PTR_LOW, TCR_OFS_SELECT, TCR_OFS_CONFIG,
          TCR_OFS_WINDOW, TCR_OFS_STATUS: s_axi_bresp <= TCR_RESP_OKAY;
          default: s_axi_bresp <= TCR_RESP_SLVERR;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Ready while the corresponding half is not yet held.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= ~aw_held_reg & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready <= ~w_held_reg & ~(s_axi_wvalid & s_axi_wready);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pointer registers; only byte lane 0 carries data.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ram_pointer_low_reg <= TCR_BYTE_RST;
      ptr_high_reg <= TCR_BYTE_RST;
    end
    else if (wr_fire && wlane_reg)
    begin
      if (waddr_reg == TCR_OFS_PTR_LOW)
      begin
        ram_pointer_low_reg <= wr_byte;
      end
      if (waddr_reg == TCR_OFS_PTR_HIGH)
      begin
        ptr_high_reg <= wr_byte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration and the shared selector. Untouched by software reset.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_reg <= TCR_CONFIG_RST;
      sel_reg <= TCR_SEL_RST;
    end
    else if (wr_fire && wlane_reg)
    begin
      if (waddr_reg == TCR_OFS_CONFIG)
      begin
        cfg_reg <= {wr_byte[7:2], 2'b00};
        sel_reg <= {1'b0, wr_byte[1:0]};
      end
      else if (waddr_reg == TCR_OFS_SELECT)
      begin
        // Bits 7-3 are expected to be written as zero and are not stored.
        sel_reg <= wr_byte[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Indirect window registers; software reset affects only next ID here.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tent_reg <= TCR_BYTE_RST;
      node_reg <= TCR_BYTE_RST;
      setup1_reg <= TCR_BYTE_RST;
      setup2_reg <= TCR_BYTE_RST;
    end
    else if (wr_fire && wlane_reg && waddr_reg == TCR_OFS_WINDOW)
    begin
      case (sel_reg)
        TCR_WIN_TENTATIVE: tent_reg <= wr_byte;
        TCR_WIN_NODE_ID: node_reg <= wr_byte;
        TCR_WIN_SETUP1: setup1_reg <= wr_byte;
        TCR_WIN_SETUP2: setup2_reg <= wr_byte;
        default: ;
      endcase
    end
  end

  // Next ID, status and diagnostics are cleared while software reset stands.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      next_id_reg <= TCR_BYTE_RST;
      status_reg <= TCR_BYTE_RST;
      diag_reg <= TCR_BYTE_RST;
    end
    else if (sreset)
    begin
      next_id_reg <= TCR_BYTE_RST;
      status_reg <= TCR_BYTE_RST;
      diag_reg <= TCR_BYTE_RST;
    end
    else
    begin
      if (next_id_load)
      begin
        next_id_reg <= next_id_in;
      end
      // A set in the same cycle as a clear wins.
      if (wr_fire && wlane_reg && waddr_reg == TCR_OFS_STATUS)
      begin
        status_reg <= (status_reg & ~wr_byte) | status_set;
      end
      else
      begin
        status_reg <= status_reg | status_set;
      end
      diag_reg <= diag_reg | diag_set;
    end
  end

  // Interface type is caught once after hard reset, never by software reset.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      iface_reg <= 1'b0;
      iface_taken_reg <= 1'b0;
    end
    else if (!iface_taken_reg)
    begin
      iface_reg <= host_iface_mode;
      iface_taken_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read channel: one cycle to answer; unmapped offsets answer SLVERR.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= TCR_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= TCR_RESP_OKAY;
        case (s_axi_araddr)
          TCR_OFS_PTR_LOW: s_axi_rdata <= {24'h000000, ram_pointer_low_reg};
          TCR_OFS_PTR_HIGH: s_axi_rdata <= {24'h000000, ptr_high_reg};
          TCR_OFS_SELECT: s_axi_rdata <= {29'h0, sel_reg};
          TCR_OFS_CONFIG: s_axi_rdata <= {24'h000000, cfg_reg[7:2], sel_reg[1:0]};
          TCR_OFS_STATUS: s_axi_rdata <= {24'h000000, status_reg};
          TCR_OFS_DIAG: s_axi_rdata <= {24'h000000, diag_reg};
          TCR_OFS_WINDOW: s_axi_rdata <= {24'h000000, win_read(sel_reg, tent_reg,
                                          node_reg, setup1_reg, next_id_reg,
                                          setup2_reg)};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= TCR_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registered outputs to the rest of the controller.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ram_addr <= 11'h000;
      chaining_enable <= 1'b0;
      soft_reset <= 1'b0;
      iface_mode <= 1'b0;
      tentative_id <= 8'h00;
      node_id <= 8'h00;
      setup1 <= 8'h00;
      setup2 <= 8'h00;
    end
    else
    begin
      ram_addr <= {ptr_high_reg[2:0], ram_pointer_low_reg};
      chaining_enable <= cfg_reg[TCR_CFG_CHAIN_BIT];
      soft_reset <= sreset;
      iface_mode <= iface_reg;
      tentative_id <= tent_reg;
      node_id <= node_reg;
      setup1 <= setup1_reg;
      setup2 <= setup2_reg;
    end
  end

  // Line output gating.
  tcr_line_gate u_gate (
    .clk(clk),
    .rst(rst),
    .transmit_enable_bit(cfg_reg[TCR_CFG_TRANSMIT_ENABLE_BIT_BIT]),
    .backplane(cfg_reg[TCR_CFG_BACKPLANE_BIT]),
    .raw_req(raw_req),
    .line_out(line_out)
  );

endmodule : tcr_regs

`default_nettype wire

//--- verif/tcr_host_model.sv
`default_nettype none
////////////////////////////////////////////////////////////
// Host processor as an AXI4-Lite master; one transfer per task call.
module tcr_host_model
  import tcr_pkg::*;
(
  input wire logic clk,
  output logic [4:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [4:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 100ps;
  // Bus idle from time zero.
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // Writes one byte; the response stays unknown if the slave never answers.
  task automatic write_reg(input logic [4:0] a, input logic [7:0] d, output logic [1:0] r);
    r = 2'bxx;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, a == TCR_OFS_SELECT ? {5'h0, d[2:0]} : d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(posedge clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : write_reg
  // Reads one word under the same bound.
  task automatic read_reg(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    r = 2'bxx;
    d = 'x;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(posedge clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        r = s_axi_rresp;
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : read_reg
endmodule : tcr_host_model
`default_nettype wire

//--- verif/tcr_regs_assertions.sv
`default_nettype none
////////////////////////////////////////////////////////////
// Watches the register block ports against a shadow of the host writes.
module tcr_regs_checker
  import tcr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire tcr_line_t raw_req,
  input wire logic [10:0] ram_addr,
  input wire logic chaining_enable,
  input wire logic soft_reset,
  input wire logic iface_mode,
  input wire tcr_line_t line_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] aw_q, ar_q; // Addresses taken by the bus.
  logic [7:0] w_q; // Data byte taken by the bus.
  logic [2:0] sel_q; // Expected selector.
  logic ws_q, bv_d, rv_d, transmit_enable_bit_q;
  logic wr_new, rd_new;
  assign wr_new = s_axi_bvalid && !bv_d;
  assign rd_new = s_axi_rvalid && !rv_d;
  // Captures each transfer as the bus takes it.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      aw_q <= 5'h00;
      ar_q <= 5'h00;
      w_q <= 8'h00;
      ws_q <= 1'b0;
      bv_d <= 1'b0;
      rv_d <= 1'b0;
    end
    else
    begin
      bv_d <= s_axi_bvalid;
      rv_d <= s_axi_rvalid;
      if (s_axi_awvalid && s_axi_awready)
        aw_q <= s_axi_awaddr;
      if (s_axi_arvalid && s_axi_arready)
        ar_q <= s_axi_araddr;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_q <= s_axi_wdata[7:0];
        ws_q <= s_axi_wstrb[0];
      end
    end
  end
  // Mirrors the shared selector and transmit enable once a write completes.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sel_q <= TCR_SEL_RST;
      transmit_enable_bit_q <= 1'b0;
    end
    else if (wr_new && ws_q && aw_q == TCR_OFS_SELECT)
      sel_q <= w_q[2:0];
    else if (wr_new && ws_q && aw_q == TCR_OFS_CONFIG)
    begin
      sel_q <= {1'b0, w_q[1:0]};
      transmit_enable_bit_q <= w_q[TCR_CFG_TRANSMIT_ENABLE_BIT_BIT];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_RESET_OUT: assert property ($past(rst) |-> line_out == '0 && !soft_reset)
    else $error("outputs not idle after reset");
  AST_CHAIN: assert property (wr_new && ws_q && aw_q == TCR_OFS_CONFIG
    |-> ##[0:2] chaining_enable == w_q[6]) else $error("chaining enable wrong");
  AST_SOFT_RESET: assert property (wr_new && ws_q && aw_q == TCR_OFS_CONFIG
    |-> ##[0:2] soft_reset == w_q[7]) else $error("soft reset wrong");
  AST_PTR_LOW: assert property (wr_new && ws_q && aw_q == TCR_OFS_PTR_LOW
    |-> ##[0:2] ram_addr[7:0] == w_q) else $error("low address wrong");
  AST_PTR_HIGH: assert property (wr_new && ws_q && aw_q == TCR_OFS_PTR_HIGH
    |-> ##[0:2] ram_addr[10:8] == w_q[2:0]) else $error("high address wrong");
  AST_SEL_READ: assert property (rd_new && ar_q == TCR_OFS_SELECT
    |-> s_axi_rdata == {29'h0, sel_q}) else $error("selector read wrong");
  AST_CFG_SEL: assert property (rd_new && ar_q == TCR_OFS_CONFIG
    |-> s_axi_rdata[1:0] == sel_q[1:0] && s_axi_rdata[5] == transmit_enable_bit_q) else $error("config read");
  AST_WIN_RSV: assert property (rd_new && ar_q == TCR_OFS_WINDOW && sel_q > 3'h4
    |-> s_axi_rdata == '0) else $error("reserved window read not zero");
  AST_TX_GATE: assert property (line_out.line_driver_enable_out
    |-> $past(raw_req.line_driver_enable_out) && (transmit_enable_bit_q || $past(transmit_enable_bit_q)))
    else $error("driver enable active while disabled");
  AST_IFACE: assert property (soft_reset |-> $stable(iface_mode))
    else $error("interface type changed");
endmodule : tcr_regs_checker

bind tcr_regs tcr_regs_checker u_chk
(
  .clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .raw_req(raw_req), .ram_addr(ram_addr), .chaining_enable(chaining_enable),
  .soft_reset(soft_reset), .iface_mode(iface_mode), .line_out(line_out)
);
`default_nettype wire

//--- verif/token_ctrl_ptr_subaddr_config_regs_tb_top.sv
`default_nettype none
////////////////////////////////////////////////////////////
// Self-checking bench for the pointer, selector and configuration registers.
module token_ctrl_ptr_subaddr_config_regs_tb_top
  import tcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [1:0] OK = TCR_RESP_OKAY;
  localparam logic [1:0] ERR = TCR_RESP_SLVERR;
  typedef struct packed {logic [4:0] a; logic [7:0] d; logic [7:0] e;} tcr_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic host_iface_mode = 1'b1;
  logic [7:0] status_set = 8'h00;
  logic [7:0] diag_set = 8'h00;
  logic [7:0] next_id_in = 8'h00;
  logic next_id_load = 1'b0;
  tcr_line_t raw_req = '0;
  logic [10:0] ram_addr;
  logic chaining_enable, soft_reset, iface_mode;
  logic [7:0] tentative_id, node_id, setup1, setup2;
  tcr_line_t line_out;
  int mismatches = 0;
  int cmp_count = 0;
  // Plain register rows: address, byte written, byte read back.
  tcr_row_t rows [4] = '{'{TCR_OFS_PTR_LOW, 8'ha5, 8'ha5}, '{TCR_OFS_PTR_HIGH, 8'h05, 8'h05},
    '{TCR_OFS_SELECT, 8'hfc, 8'h04}, '{TCR_OFS_CONFIG, 8'h41, 8'h41}};
  always #12.5 clk = ~clk;
  tcr_regs DUT (.*);
  tcr_host_model u_host (.*);
  // Compares one value and reports a difference.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run
  // Bus write with its expected response; a hung bus ends the run.
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
    logic [1:0] r;
    u_host.write_reg(a, d, r);
    check(32'(r), 32'(er));
    if (r === 2'bxx)
      complete_run();
  endtask : wr
  // Bus read with expected byte and response.
  task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    u_host.read_reg(a, d, r);
    check(32'(r), 32'(er));
    check(d, 32'(e));
    if (r === 2'bxx)
      complete_run();
  endtask : rd
  // Main sequence.
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    next_id_in <= 8'h3c;
    next_id_load <= 1'b1;
    @(posedge clk);
    next_id_load <= 1'b0;
    rd(TCR_OFS_CONFIG, 8'h00, OK);
    check(32'({line_out, soft_reset, iface_mode}), 32'h01);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d, OK);
      rd(rows[i].a, rows[i].e, OK);
    end
    check(32'({ram_addr, chaining_enable}), 32'hb4b);
    wr(TCR_OFS_SELECT, 8'h04, OK);
    wr(TCR_OFS_CONFIG, 8'h02, OK);
    rd(TCR_OFS_SELECT, 8'h02, OK);
    check(32'(chaining_enable), 32'h0);
    wr(TCR_OFS_SELECT, 8'h01, OK);
    rd(TCR_OFS_CONFIG, 8'h01, OK);
    for (int i = 0; i < 8; i++)
    begin
      wr(TCR_OFS_SELECT, 8'(i), OK);
      wr(TCR_OFS_WINDOW, 8'h30 + 8'(i), OK);
      rd(TCR_OFS_WINDOW, i == 3 ? 8'h3c : i > 4 ? 8'h00 : 8'h30 + 8'(i), OK);
    end
    check({tentative_id, node_id, setup1, setup2}, 32'h30313234);
    wr(5'h04, 8'hff, ERR);
    rd(5'h18, 8'h00, ERR);
    status_set <= 8'h81;
    diag_set <= 8'h42;
    @(posedge clk);
    status_set <= 8'h00;
    diag_set <= 8'h00;
    rd(TCR_OFS_STATUS, 8'h81, OK);
    rd(TCR_OFS_DIAG, 8'h42, OK);
    wr(TCR_OFS_CONFIG, 8'ha3, OK);
    rd(TCR_OFS_STATUS, 8'h00, OK);
    rd(TCR_OFS_DIAG, 8'h00, OK);
    rd(TCR_OFS_WINDOW, 8'h00, OK);
    rd(TCR_OFS_CONFIG, 8'ha3, OK);
    check(32'({soft_reset, iface_mode, node_id}), 32'h331);
    wr(TCR_OFS_CONFIG, 8'h23, OK);
    // The soft reset output follows the register one edge later; let it settle.
    @(posedge clk);
    check(32'(soft_reset), 32'h0);
    raw_req <= 3'b111;
    repeat (3) @(posedge clk);
    check(32'(line_out), 32'h7);
    wr(TCR_OFS_CONFIG, 8'h03, OK);
    repeat (3) @(posedge clk);
    check(32'(line_out), 32'h0);
    wr(TCR_OFS_CONFIG, 8'h07, OK);
    repeat (3) @(posedge clk);
    check(32'(line_out), 32'h3);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(TCR_OFS_CONFIG, 8'h00, OK);
    check(32'(line_out), 32'h0);
    complete_run();
  end
endmodule : token_ctrl_ptr_subaddr_config_regs_tb_top
`default_nettype wire
